// *** sar_ctrl_pkg.sv ***
/*
  Package for the successive-approximation conversion control block.
  Holds field widths, code values, timing figures and the register map.
  Assumes a 125 MHz core clock.
*/
package sar_ctrl_pkg;
  // Core clock rate in kHz and the data width of the result.
  localparam int CORE_CLK_KHZ = 125000;
  localparam int RESULT_W = 16;
  // Least acquisition time in ns and the least cycle time at 100 kSPS.
  localparam int ACQ_TIME_NS = 1000;
  localparam int ACQ_CYCLES = (ACQ_TIME_NS * CORE_CLK_KHZ + 999999) / 1000000;
  localparam int THROUGHPUT_KSPS = 100;
  localparam int MIN_PERIOD_CYCLES = CORE_CLK_KHZ / THROUGHPUT_KSPS;
  // Cycles per bit trial; the comparator settles on a divider pulse.
  localparam int BIT_TRIAL_CYCLES = 32;
  // Output code landmarks.
  localparam logic [15:0] CODE_ZERO = 16'h0000;
  localparam logic [15:0] CODE_MID = 16'h8000;
  localparam logic [15:0] CODE_FULL = 16'hFFFF;
  localparam logic [15:0] CODE_TWOS_MAX = 16'h7FFF;
  // Register offsets (byte addresses).
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_RESULT = 4'h8;
  // Field positions.
  localparam int CTRL_CODING_BIT = 0;
  localparam int CTRL_SLEEP_BIT = 1;
  localparam int CTRL_RESET_BIT = 2;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_SLEEP_BIT = 1;
  localparam int STAT_LOWPWR_BIT = 2;
  // Reset value of the control register.
  localparam logic [2:0] CTRL_RESET_VAL = 3'h0;
  // Controller states.
  typedef enum logic [2:0] {ST_ACQ, ST_WAIT, ST_OPEN, ST_GROUND, ST_TRIAL, ST_FORMAT} conv_state_t;
endpackage

// *** sar_step_if.sv ***
/*
  Interface between the sequencer and the bit-trial engine.
  Assumes both ends run on the same core clock.
*/
`timescale 1ns/1ps
interface sar_step_if;
  // Start pulse, step enable, comparator, result and done.
  logic start;
  logic step_en;
  logic comp;
  logic [15:0] trial;
  logic [15:0] raw;
  logic done;
  modport ctrl (output start, output step_en, input trial, input raw, input done);
  modport engine (input start, input step_en, input comp, output trial, output raw, output done);
endinterface

// *** sar_bit_engine.sv ***
/*
  Successive-approximation register: one bit per step, MSB first.
  Assumes the comparator is valid when step_en pulses.
*/
`timescale 1ns/1ps
module sar_bit_engine
  import sar_ctrl_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic abort_i,
  // Link to the sequencer.
  sar_step_if.engine stp
);
  logic [15:0] sar_r;
  logic [15:0] bit_r;
  logic done_r;

  // Trial code keeps decided bits plus the bit now under test.
  assign stp.trial = sar_r | bit_r;
  assign stp.raw = sar_r;
  assign stp.done = done_r;

  // Keep the bit when the comparator says the input is above the trial.
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i || abort_i)
    begin
      sar_r <= CODE_ZERO;
      bit_r <= CODE_ZERO;
      done_r <= 1'b0;
    end
    else if (stp.start)
    begin
      sar_r <= CODE_ZERO;
      bit_r <= CODE_MID;
      done_r <= 1'b0;
    end
    else if (stp.step_en && bit_r != CODE_ZERO)
    begin
      if (stp.comp)
        sar_r <= sar_r | bit_r;
      bit_r <= bit_r >> 1;
      done_r <= (bit_r == 16'h0001);
    end
    else
      done_r <= 1'b0;
  end
endmodule

// *** sar_conversion_control.sv ***
/*
  Conversion control of a 16-bit successive-approximation converter,
  with an Avalon-MM slave (waitrequest) for control and result access.
  The sequencer runs acquisition, switch opening, grounding, sixteen bit
  trials and formatting in turn; the bit trials live in a small engine.
  Assumes a synchronous comparator input sampled on the core clock, and a
  host that drives its pins in step with that clock.
// Overview of operation
// - Conversion starts after acquisition when start falls or is held low.
// - Open common and dummy switches first, then move caps to reference ground.
// - Resolve sixteen bits MSB first, halving steps to one in 65536.
// - After the last trial form the code, then drop busy.
// - No latency: result belongs to the sample of that conversion.
// - Coding select picks straight binary or twos complement.
// - Twos complement is straight binary with MSB inverted.
// - Overrange saturates to FFFF or 7FFF.
// - Underrange saturates to 0000 or 8000.
// - Up to 100 kSPS; host must not request faster.
// - Low power between conversions while still ready to start.
// - Busy rises when conversion starts and stays high until done.
// - Started conversion completes; start and sleep ignored until busy falls.
// - High reset returns to initial state and aborts conversion.
// - Start held low while idle runs conversions continuously.
*/
`timescale 1ns/1ps
module sar_conversion_control
  import sar_ctrl_pkg::*;
#(
  parameter int ACQ_CNT = ACQ_CYCLES,
  parameter int TRIAL_CNT = BIT_TRIAL_CYCLES
)
(
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Host control pins.
  input wire logic conversion_start_n_i,
  input wire logic coding_select_i,
  input wire logic sleep_request_i,
  input wire logic reset_i,
  // Analog front end.
  input wire logic comp_i,
  input wire logic overrange_i,
  input wire logic underrange_i,
  output logic common_node_switch_o,
  output logic dummy_node_switch_o,
  output logic reference_ground_o,
  output logic [15:0] dac_code_o,
  output logic low_power_o,
  // Conversion status and data.
  output logic busy_o,
  output logic [15:0] result_o,
  // Avalon-MM slave.
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  import sar_ctrl_pkg::*;

  // Elaboration checks: the counters are 16 bits wide, and a bit trial needs one
  // cycle to present the trial code and one more to sample the comparator.
  if (ACQ_CNT < 1)
  begin : g_acq_too_small
    $error("ACQ_CNT must be at least 1.");
  end
  if (ACQ_CNT > 65536)
  begin : g_acq_too_large
    $error("ACQ_CNT must fit the 16-bit counter.");
  end
  if (TRIAL_CNT < 2)
  begin : g_trial_too_small
    $error("TRIAL_CNT must be at least 2.");
  end
  if (TRIAL_CNT > 65536)
  begin : g_trial_too_large
    $error("TRIAL_CNT must fit the 16-bit counter.");
  end
  if (MIN_PERIOD_CYCLES > 65535)
  begin : g_period_too_long
    $error("The minimum cycle period must fit the 16-bit period counter.");
  end

  sar_step_if stp ();
  conv_state_t state_r, state_nxt;
  logic [15:0] cnt_r;
  logic [15:0] period_r;
  logic start_d_r;
  logic [2:0] ctrl_r;
  logic [15:0] result_r;
  logic busy_r;
  logic lowpwr_r;
  logic sw_open_r;
  logic reference_ground_r;
  logic ack_r;
  logic [31:0] rdata_r;

  // Effective control: pins or-ed with software bits.
  wire coding_eff = coding_select_i | ctrl_r[CTRL_CODING_BIT];
  wire sleep_eff = sleep_request_i | ctrl_r[CTRL_SLEEP_BIT];
  wire abort = reset_i | ctrl_r[CTRL_RESET_BIT];
  wire start_fall = start_d_r & ~conversion_start_n_i;
  wire start_low = ~conversion_start_n_i;
  wire acq_done = (cnt_r == 16'h0000);
  wire rate_ok = (period_r >= 16'(MIN_PERIOD_CYCLES - 1));
  wire go = acq_done && rate_ok && !sleep_eff && (start_fall || start_low);
  wire step_tick = (state_r == ST_TRIAL) && (cnt_r == 16'h0000);

  // Counter reload values, cut to the counter width on purpose.
  wire [15:0] acq_reload = 16'(ACQ_CNT - 1);
  wire [15:0] trial_reload = 16'(TRIAL_CNT - 1);

  // Phase events shared by the sequencer, the flag registers and the result.
  wire conv_begin = (state_r == ST_WAIT) && go;
  wire open_tick = (state_r == ST_OPEN);
  wire last_trial = (state_r == ST_TRIAL) && stp.done;
  wire conv_finish = (state_r == ST_FORMAT);

  // Bit trial engine.
  sar_bit_engine u_engine (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .abort_i(abort),
    .stp(stp)
  );
  assign stp.comp = comp_i;
  assign stp.start = (state_r == ST_GROUND) && (cnt_r == 16'h0000);
  assign stp.step_en = step_tick;

  // Output coding: saturation first, then optional MSB inversion.
  wire [15:0] sat_code = overrange_i ? CODE_FULL : (underrange_i ? CODE_ZERO : stp.raw);
  wire [15:0] coded;

  // Per-bit coding: only the top bit differs between straight binary and twos
  // complement, so the lower bits pass straight through.
  for (genvar b = 0; b < 16; b++)
  begin : g_code
    if (b == 15)
    begin : g_msb
      assign coded[b] = coding_eff ? sat_code[b] : ~sat_code[b];
    end
    else
    begin : g_low
      assign coded[b] = sat_code[b];
    end
  end

  // Next state of the sequencer.
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      // Acquisition: the array tracks the input until the count runs out.
      ST_ACQ:
      begin
        if (acq_done)
          state_nxt = ST_WAIT;
      end
      // Waiting: a falling or held-low start begins a conversion when allowed.
      ST_WAIT:
      begin
        if (go)
          state_nxt = ST_OPEN;
      end
      // Switch opening: one cycle before the array is moved to ground.
      ST_OPEN:
      begin
        if (cnt_r == 16'h0000)
          state_nxt = ST_GROUND;
      end
      // Grounding: the array moves to reference ground and the engine loads.
      ST_GROUND:
      begin
        if (cnt_r == 16'h0000)
          state_nxt = ST_TRIAL;
      end
      // Bit trials: sixteen of them, ended by the engine's done pulse.
      ST_TRIAL:
      begin
        if (stp.done)
          state_nxt = ST_FORMAT;
      end
      // Format: the code is already held; busy falls on the way out.
      ST_FORMAT:
      begin
        state_nxt = ST_ACQ;
      end
      // Unused encodings return to acquisition.
      default:
      begin
        state_nxt = ST_ACQ;
      end
    endcase
  end

  // Sequencer registers; a started conversion ignores start and sleep.
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i || abort)
    begin
      state_r <= ST_ACQ;
      cnt_r <= 16'(ACQ_CNT - 1);
      period_r <= 16'(MIN_PERIOD_CYCLES - 1);
      start_d_r <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
      start_d_r <= conversion_start_n_i;
      if (period_r != 16'hFFFF)
        period_r <= period_r + 16'h0001;
      if (state_nxt != state_r)
      begin
        // Each phase starts its count afresh; open and ground last one cycle.
        case (state_nxt)
          ST_ACQ:
          begin
            cnt_r <= acq_reload;
          end
          ST_TRIAL:
          begin
            cnt_r <= trial_reload;
          end
          default:
          begin
            cnt_r <= 16'h0000;
          end
        endcase
      end
      else if (step_tick)
        cnt_r <= 16'(TRIAL_CNT - 1);
      else if (cnt_r != 16'h0000)
        cnt_r <= cnt_r - 16'h0001;
      if (conv_begin)
        period_r <= 16'h0000;
    end
  end

  // Conversion flags: busy and the open switches rise together as a
  // conversion begins, and reference ground follows one cycle later so the
  // array is never moved while the common node is still closed.
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i || abort)
    begin
      busy_r <= 1'b0;
      sw_open_r <= 1'b0;
      reference_ground_r <= 1'b0;
    end
    else if (conv_begin)
    begin
      busy_r <= 1'b1;
      sw_open_r <= 1'b1;
    end
    else if (open_tick)
    begin
      reference_ground_r <= 1'b1;
    end
    else if (conv_finish)
    begin
      busy_r <= 1'b0;
      sw_open_r <= 1'b0;
      reference_ground_r <= 1'b0;
    end
  end

  // Result capture: written at the end of the last trial, held until the next one or until a reset or abort clears it.
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i || abort)
      result_r <= CODE_ZERO;
    else if (last_trial)
      result_r <= coded;
  end

  // Low power while waiting for a start, or while asleep when idle.
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      lowpwr_r <= 1'b0;
    else
      lowpwr_r <= (state_nxt == ST_WAIT) || (state_nxt == ST_ACQ && sleep_eff);
  end

  // Pin outputs; the trial code is the DAC setting during bit trials.
  assign busy_o = busy_r;
  assign result_o = result_r;
  assign common_node_switch_o = ~sw_open_r;
  assign dummy_node_switch_o = ~sw_open_r;
  assign reference_ground_o = reference_ground_r;
  assign dac_code_o = (state_r == ST_TRIAL) ? stp.trial : CODE_ZERO;
  assign low_power_o = lowpwr_r;

  // Bus decode; every access takes one wait cycle so data comes from flops.
  wire req = avs_read | avs_write;
  wire hit_ctrl = (avs_address == REG_CTRL);
  wire hit_status = (avs_address == REG_STATUS);
  wire hit_result = (avs_address == REG_RESULT);
  wire [31:0] status_word = {29'h0000_0000, lowpwr_r, sleep_eff, busy_r};
  wire [31:0] ctrl_word = {29'h0000_0000, ctrl_r};
  wire [31:0] result_word = {16'h0000, result_r};

  // Read selection; an offset that matches nothing reads as zero.
  wire [31:0] rd_mux = hit_ctrl ? ctrl_word :
                       hit_status ? status_word :
                       hit_result ? result_word : 32'h0000_0000;
  assign avs_waitrequest = req & ~ack_r;
  assign avs_readdata = rdata_r;

  // Bus strobes: the answer comes one cycle after the request, and a write
  // lands only on the edge at which the master sees waitrequest low.
  wire bus_first = req & ~ack_r;
  wire ctrl_wr = avs_write & ack_r & hit_ctrl;

  // Handshake and read data; unmapped reads return zero.
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      ack_r <= bus_first;
      if (bus_first)
        rdata_r <= rd_mux;
    end
  end

  // Control register; writes to other offsets are dropped. Soft reset stays
  // set until software clears it, holding the sequencer idle meanwhile.
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      ctrl_r <= CTRL_RESET_VAL;
    else if (ctrl_wr)
      ctrl_r <= avs_writedata[2:0];
  end
endmodule

// *** sar_ctrl_props.sv ***
/* Checker for the conversion control block, bound to its top module.
   Assumes a trial count small enough for the conversion window below. */
`timescale 1ns/1ps
module sar_ctrl_props
  import sar_ctrl_pkg::*;
#(parameter int ACQ_CNT = 2, parameter int TRIAL_CNT = 2)
(
  // Watched ports.
  input wire logic core_clk_i, rst_n_i, reset_i, sleep_request_i, coding_select_i, overrange_i, underrange_i,
  input wire logic common_node_switch_o, dummy_node_switch_o, reference_ground_o, busy_o,
  input wire logic [15:0] dac_code_o, result_o
);
  // Either reset silences the checks, since both abort a conversion.
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i || reset_i);
  // Open, ground, sixteen trials of TRIAL_CNT cycles, done and format.
  localparam int CONV_LO = 16 * TRIAL_CNT + 4;
  localparam int CONV_HI = 16 * TRIAL_CNT + 6;
  sequence conv_open;
    $fell(common_node_switch_o) && !dummy_node_switch_o;
  endsequence
  sequence conv_end;
    $fell(busy_o);
  endsequence
  sw_open_a: assert property ($rose(busy_o) |-> conv_open)
    else $error("switches not opened at start");
  gnd_after_a: assert property (conv_open |-> !reference_ground_o ##1 reference_ground_o)
    else $error("reference ground out of order");
  msb_first_a: assert property ($rose(reference_ground_o) |-> ##[1:3] dac_code_o == CODE_MID)
    else $error("first trial not the top bit");
  busy_hold_a: assert property ($rose(busy_o) |=> busy_o[*8])
    else $error("busy dropped early");
  conv_len_a: assert property ($rose(busy_o) |-> ##[CONV_LO:CONV_HI] conv_end)
    else $error("conversion length wrong");
  keep_res_a: assert property ($changed(result_o) && $past(rst_n_i) && !$past(reset_i) |-> ##1 conv_end)
    else $error("result changed without completion");
  over_sat_a: assert property (conv_end and overrange_i |-> result_o == (coding_select_i ? CODE_FULL : CODE_TWOS_MAX))
    else $error("overrange code wrong");
  under_sat_a: assert property (conv_end and underrange_i |-> result_o == (coding_select_i ? CODE_ZERO : CODE_MID))
    else $error("underrange code wrong");
  sleep_hold_a: assert property (sleep_request_i && $past(sleep_request_i) && !busy_o |=> !busy_o)
    else $error("conversion started while asleep");
endmodule
bind sar_conversion_control sar_ctrl_props #(.ACQ_CNT(ACQ_CNT), .TRIAL_CNT(TRIAL_CNT)) i_sar_ctrl_props (.core_clk_i,
  .rst_n_i, .reset_i, .sleep_request_i, .coding_select_i, .overrange_i, .underrange_i, .common_node_switch_o,
  .dummy_node_switch_o, .reference_ground_o, .busy_o, .dac_code_o, .result_o);

// *** sar_front_model.sv ***
/* Front-end model: captures the input level as the common switch opens
   and compares it with the trial code. Assumes one core clock. */
`timescale 1ns/1ps
module sar_front_model
(
  // Clock and front-end pins.
  input wire logic core_clk_i,
  input wire logic common_node_switch_i,
  input wire logic [15:0] dac_code_i,
  input wire logic [15:0] level_i,
  output logic comp_o
);
  logic [15:0] held_r = 16'h0000;
  logic sw_r = 1'b1;
  // Capture once, so later input moves cannot leak into the result.
  always_ff @(posedge core_clk_i)
  begin
    sw_r <= common_node_switch_i;
    if (sw_r && !common_node_switch_i)
      held_r <= level_i;
  end
  // Keep the tested bit while the trial does not exceed the held level.
  assign comp_o = dac_code_i <= held_r;
endmodule

// *** tb_sar_conversion_control.sv ***
/* Bench: codings, saturation, free running, abort and bus reads.
   Assumes the front-end model and small count parameters. */
`timescale 1ns/1ps
module tb_sar_conversion_control;
  import sar_ctrl_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, stn = 1'b1, cs = 1'b1, slp = 1'b0, rpin = 1'b0, ovr = 1'b0, und = 1'b0;
  logic rd = 1'b0, wr = 1'b0, comp, sw_c, sw_d, gnd, lp, busy, wreq;
  logic [3:0] addr = 4'h0;
  logic [15:0] lvl = 16'h0000, dac, res;
  logic [31:0] wd = 32'h0000_0000, rdat, q;
  logic [15:0] lv [4] = '{16'h0000, 16'h8000, 16'hFFFF, 16'h1234};
  int err_total = 0, samples_checked = 0;
  // Free-running 125 MHz clock.
  always #4 clk = ~clk;
  sar_conversion_control #(.ACQ_CNT(2), .TRIAL_CNT(2)) i_sar_conversion_control (.core_clk_i(clk), .rst_n_i(rstn),
    .conversion_start_n_i(stn), .coding_select_i(cs), .sleep_request_i(slp), .reset_i(rpin), .comp_i(comp),
    .overrange_i(ovr), .underrange_i(und), .common_node_switch_o(sw_c), .dummy_node_switch_o(sw_d),
    .reference_ground_o(gnd), .dac_code_o(dac), .low_power_o(lp), .busy_o(busy), .result_o(res),
    .avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdat),
    .avs_waitrequest(wreq));
  sar_front_model i_sar_front_model (.core_clk_i(clk), .common_node_switch_i(sw_c), .dac_code_i(dac),
    .level_i(lvl), .comp_o(comp));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Every wait is bounded; running out counts as a mismatch.
  task automatic wait_busy(input logic b);
    int n;
    n = 0;
    while (busy !== b)
    begin
      @(posedge clk);
      n++;
      if (n > 3000)
      begin
        err_total++;
        give_verdict();
      end
    end
  endtask
  // One bus access; the request holds until waitrequest is seen low.
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    rd <= !w;
    wr <= w;
    addr <= a;
    wd <= d;
    do
    begin
      @(posedge clk);
      n++;
      if (n > 50)
      begin
        err_total++;
        give_verdict();
      end
    end
    while (wreq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  // Input and sleep move mid-conversion; neither may touch that result.
  task automatic convert(input logic [15:0] l, input logic c, input logic [15:0] e);
    lvl <= l;
    cs <= c;
    stn <= 1'b0;
    wait_busy(1'b1);
    check(lp, 1'b0);
    stn <= 1'b1;
    slp <= 1'b1;
    lvl <= ~l;
    wait_busy(1'b0);
    slp <= 1'b0;
    check(res, e);
    bus(1'b0, REG_RESULT, 32'h0000_0000);
    check(q, {16'h0000, e});
    check(lp, 1'b1);
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    check(busy, 1'b0);
    check(sw_c & sw_d, 1'b1);
    bus(1'b0, 4'hC, 32'h0000_0000);
    check(q, 32'h0000_0000);
    $display("test reset done");
    for (int i = 0; i < 8; i++)
      convert(lv[i % 4], i[2], i[2] ? lv[i % 4] : lv[i % 4] ^ CODE_MID);
    for (int i = 0; i < 2; i++)
    begin
      ovr <= 1'b1;
      convert(16'h0001, i[0], i[0] ? CODE_FULL : CODE_TWOS_MAX);
      ovr <= 1'b0;
      und <= 1'b1;
      convert(16'h0001, i[0], i[0] ? CODE_ZERO : CODE_MID);
      und <= 1'b0;
    end
    bus(1'b1, REG_CTRL, 32'h0000_0001);
    bus(1'b0, REG_CTRL, 32'h0000_0000);
    check(q, 32'h0000_0001);
    convert(16'h1234, 1'b0, 16'h1234);
    bus(1'b1, REG_CTRL, 32'h0000_0000);
    $display("test codings done");
    // Start held low keeps conversions running on their own.
    lvl <= 16'h4321;
    stn <= 1'b0;
    wait_busy(1'b1);
    wait_busy(1'b0);
    wait_busy(1'b1);
    wait_busy(1'b0);
    check(res, 16'hC321);
    $display("test free run done");
    wait_busy(1'b1);
    stn <= 1'b1;
    repeat (4) @(posedge clk);
    rpin <= 1'b1;
    @(posedge clk);
    rpin <= 1'b0;
    repeat (2) @(posedge clk);
    check(busy, 1'b0);
    check({sw_c, res}, {1'b1, CODE_ZERO});
    $display("test abort done");
    give_verdict();
  end
endmodule
